// ### mul_literal_regs.svh
// Constants for the multiply-literal datapath: widths, field positions, opcode and reset values.
// Assumes inclusion by the package and the datapath files only.
`ifndef MUL_LITERAL_REGS_SVH
`define MUL_LITERAL_REGS_SVH
`define OPND_W 8
`define PROD_W 16
`define PROD_HI_MSB 15
`define PROD_HI_LSB 8
`define PROD_LO_MSB 7
`define PROD_LO_LSB 0
`define OPCODE_MSB 15
`define OPCODE_LSB 8
`define MUL_LITERAL_OPCODE 8'h0d
`define PROD_RESET 16'h0000
`define BYTE_RESET 8'h00
`endif

// ### mul_literal_pkg.sv
// Types shared by the multiply-literal datapath files.
// Assumes the constants header sits in the same folder.
`include "mul_literal_regs.svh"
package mul_literal_pkg;
  // Four phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_t;

  // Instruction issued by the decoder together with the operand
  typedef struct packed {
    logic valid;
    logic [15:0] insn;
    logic [`OPND_W-1:0] wreg;
  } issue_t;

  // Product pair as it leaves the block
  typedef struct packed {
    logic [`OPND_W-1:0] high_byte;
    logic [`OPND_W-1:0] low_byte;
  } prod_pair_t;
endpackage

// ### mul_unsigned.sv
// Unsigned 8 x 8 multiplier, purely combinational.
// Assumes its operands are stable over the process phase.
`timescale 1ns/1ps
module mul_unsigned #(
  parameter int WIDTH = 8
) (
  // Operands
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  // Result
  output logic [2*WIDTH-1:0] p
);
  // Widen first so no product bit is lost
  always_comb begin
    p = {{WIDTH{1'b0}}, a} * {{WIDTH{1'b0}}, b};
  end
endmodule

// ### multiply_literal_datapath.sv
// Datapath of the multiply-literal instruction: W times an 8-bit literal into the product pair.
// The instruction runs in four phases on the core clock; the pair is loaded on the edge that
// closes the write phase and a one-cycle done pulse rises on that same edge.
// Status flags and W are carried through one register stage and never altered, so the
// surrounding core can see that the instruction left them alone.
// Assumes the decoder holds the issue word steady from the decode phase until the write phase,
// and that issue and status come from logic on the same clock, so no synchroniser is needed.
`timescale 1ns/1ps
`include "mul_literal_regs.svh"
module multiply_literal_datapath (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Issue from the instruction decoder, same clock domain
  input wire mul_literal_pkg::issue_t issue,
  input wire logic [`OPND_W-1:0] status_in,
  // Results
  output mul_literal_pkg::prod_pair_t prod_r,
  output logic [`OPND_W-1:0] status_r,
  output logic [`OPND_W-1:0] wreg_r,
  output logic done_r,
  output mul_literal_pkg::phase_t phase_r
);
  import mul_literal_pkg::*;

  // Sequencer state beyond the phase itself
  logic busy_r;
  // Operands held for the multiplier; both stay put until the next instruction
  logic [`OPND_W-1:0] lit_r;
  logic [`OPND_W-1:0] opw_r;
  // Product registered in the process phase, and the multiplier's raw output
  logic [`PROD_W-1:0] prod_res_r;
  logic [`PROD_W-1:0] prod_c;
  // High for the one edge at which an instruction is taken
  logic start;

  // Opcode match on the upper byte of the instruction word; used by the
  // start gate and by the refusal check below
  function automatic logic is_mul_literal(input logic [15:0] insn);
    return insn[`OPCODE_MSB:`OPCODE_LSB] == `MUL_LITERAL_OPCODE;
  endfunction

  // A word is taken only when idle; busy_r makes a held word harmless while
  // the four phases run, since the decoder keeps it up past the decode phase
  assign start = issue.valid && is_mul_literal(issue.insn) && !busy_r;

  // Phase sequencer: decode, read, process, write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= PH_DECODE;
      busy_r <= 1'b0;
    end else begin
      case (phase_r)
        PH_DECODE: begin
          if (start) begin
            phase_r <= PH_READ;
            busy_r <= 1'b1;
          end
        end
        // The literal is taken on the edge that leaves this phase
        PH_READ: phase_r <= PH_PROCESS;
        // The multiplier settles here; its result is registered on leaving
        PH_PROCESS: phase_r <= PH_WRITE;
        // Back to idle; a new word may be taken on the very next edge
        PH_WRITE: begin
          phase_r <= PH_DECODE;
          busy_r <= 1'b0;
        end
        // Unreachable with four states; kept so a corrupted phase recovers
        default: phase_r <= PH_DECODE;
      endcase
    end
  end

  // Capture W at decode and the literal in the read phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opw_r <= `BYTE_RESET;
      lit_r <= `BYTE_RESET;
    end else begin
      if (phase_r == PH_DECODE && start) begin
        opw_r <= issue.wreg;
      end
      if (phase_r == PH_READ) begin
        lit_r <= issue.insn[7:0];
      end
    end
  end

  // Combinational multiplier; it has a whole phase to settle before its
  // result is registered
  mul_unsigned #(.WIDTH(`OPND_W)) u_mul (
    .a(opw_r),
    .b(lit_r),
    .p(prod_c)
  );

  // Process phase registers the product so the write phase only moves it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prod_res_r <= `PROD_RESET;
    end else if (phase_r == PH_PROCESS) begin
      prod_res_r <= prod_c;
    end
  end

  // Product pair write, high byte from the upper half; done follows the same edge
  // so a consumer sees the new pair and the pulse together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prod_r <= `PROD_RESET;
      done_r <= 1'b0;
    end else begin
      done_r <= (phase_r == PH_WRITE);
      if (phase_r == PH_WRITE) begin
        prod_r.high_byte <= prod_res_r[`PROD_HI_MSB:`PROD_HI_LSB];
        prod_r.low_byte <= prod_res_r[`PROD_LO_MSB:`PROD_LO_LSB];
      end
    end
  end

  // Status and W pass through untouched; zero, carry and overflow are never computed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= `BYTE_RESET;
      wreg_r <= `BYTE_RESET;
    end else begin
      status_r <= status_in;
      wreg_r <= issue.wreg;
    end
  end

  // Every check runs on the core clock and is muted while reset is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // The expected product is formed from the issue word itself, not from the
  // multiplier, so a broken multiplier cannot agree with itself here; W is
  // taken at the taking edge and the literal one edge later, hence depths 4 and 3
  prod_value_a: assert property (start |-> ##4 prod_r ==
    16'($past(issue.wreg, 4)) * 16'($past(issue.insn[7:0], 3)))
    else $error("product pair does not hold the product");

  // The high byte must come from the upper half of the registered product
  prod_high_a: assert property (done_r |-> prod_r.high_byte == $past(prod_res_r[15:8]))
    else $error("high byte wrong");

  // All sixteen bits arrive: the pair equals W times the literal held for the multiplier
  prod_full_a: assert property (done_r |->
    {prod_r.high_byte, prod_r.low_byte} == $past(opw_r) * $past(lit_r, 2))
    else $error("product bits lost");

  // Status is only ever a one-cycle copy of the incoming flags; the first edge
  // after reset is skipped, since the copy still held its reset value then
  status_keep_a: assert property ($past(rst_n) |-> status_r == $past(status_in))
    else $error("status flag altered");

  // A zero product is the case most tempting to flag, so it gets its own check
  zero_quiet_a: assert property (done_r && prod_r == 16'h0000 |-> status_r == $past(status_in))
    else $error("zero product flagged");

  // Four phases in order, then the done pulse
  phase_walk_a: assert property (start |=> phase_r == PH_READ ##1 phase_r == PH_PROCESS
    ##1 phase_r == PH_WRITE ##1 done_r)
    else $error("phase order broken");

  // W leaves as it came in, one register stage later
  wreg_keep_a: assert property ($past(rst_n) |-> wreg_r == $past(issue.wreg))
    else $error("W modified");

  // The pair only moves on the edge that closes the write phase
  prod_hold_a: assert property (!done_r |-> $stable(prod_r) or $past(phase_r) == PH_WRITE)
    else $error("product pair changed outside write");

  // busy_r and the phase must agree, or a word could be taken mid-instruction
  busy_phase_a: assert property (busy_r == (phase_r != PH_DECODE))
    else $error("busy flag out of step with the phase");

  // A word that is taken always finds the sequencer idle
  start_idle_a: assert property (start |-> phase_r == PH_DECODE)
    else $error("word taken outside the decode phase");

  // A word with another opcode leaves the sequencer idle and the pair alone
  opcode_refuse_a: assert property (phase_r == PH_DECODE && issue.valid && !is_mul_literal(issue.insn)
    |=> phase_r == PH_DECODE && $stable(prod_r))
    else $error("other opcode started the multiply");

  // Leaving the write phase always raises done
  write_done_a: assert property (phase_r == PH_WRITE |=> done_r)
    else $error("write phase without done");

  // Done is a single-cycle pulse, even with instructions back to back
  done_pulse_a: assert property (done_r |=> !done_r)
    else $error("done held too long");

  // A word taken in the done cycle starts at once, so instructions can follow
  // one another every four cycles
  back_start_a: assert property (done_r && start |=> phase_r == PH_READ)
    else $error("back-to-back word lost");

  // The literal register only loads in the read phase; a later change would
  // corrupt a product still being formed
  lit_hold_a: assert property (phase_r != PH_READ |=> $stable(lit_r))
    else $error("literal changed outside the read phase");

  // W is only taken on the edge that starts the instruction
  opw_hold_a: assert property (!start |=> $stable(opw_r))
    else $error("W operand changed without a start");

  // The product register only loads in the process phase
  res_hold_a: assert property (phase_r != PH_PROCESS |=> $stable(prod_res_r))
    else $error("product register changed outside the process phase");

  // Main scenarios: a start, a finish, both ends of the product range and a
  // refused opcode; the bench steers through each of them
  start_seen_c: cover property (start);
  done_seen_c: cover property (done_r);
  zero_prod_c: cover property (done_r && prod_r == 16'h0000);
  max_prod_c: cover property (done_r && prod_r == 16'hfe01);
  refuse_seen_c: cover property (issue.valid && !is_mul_literal(issue.insn));
endmodule

// ### mul_decoder_model.sv
// Decoder stand-in: presents one issue word and holds it over all four phases.
// Assumes the datapath takes the word at the first edge after it is driven.
`timescale 1ns/1ps
module mul_decoder_model (
  // Clock
  input wire logic clk,
  // Issue to the datapath
  output mul_literal_pkg::issue_t issue
);
  import mul_literal_pkg::*;
  initial issue = '0;
  // Idle word is inverted so a stale copy can never pass for a live request
  task automatic run(input logic [7:0] w, input logic [7:0] k, input logic [7:0] op);
    @(posedge clk);
    #1 issue = '{1'b1, {op, k}, w};
    // Held through the write edge only; one edge more would be taken again
    repeat (4) @(posedge clk);
    #1 issue = '{1'b0, ~{op, k}, ~w};
  endtask
endmodule

// ### multiply_literal_datapath_tb.sv
// Bench for the multiply-literal datapath: example, boundary products, refusal.
// Assumes the decoder model holds the word until the done pulse is seen.
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module multiply_literal_datapath_tb;
  import mul_literal_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] status_in = 8'h5a;
  issue_t issue;
  prod_pair_t prod_r;
  logic [7:0] status_r;
  logic [7:0] wreg_r;
  logic done_r;
  phase_t phase_r;
  int mismatches = 0;
  int tests_run = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  multiply_literal_datapath multiply_literal_datapath_inst (.clk(clk), .rst_n(rst_n), .issue(issue),
    .status_in(status_in), .prod_r(prod_r), .status_r(status_r), .wreg_r(wreg_r), .done_r(done_r),
    .phase_r(phase_r));
  mul_decoder_model mul_decoder_model_inst (.clk(clk), .issue(issue));
  // Worked example from the instruction description
  task automatic t_example;
    mul_decoder_model_inst.run(8'he2, 8'hc4, 8'h0d);
    `CHK("done", 1'b1, done_r)
    `CHK("prod", 16'had08, prod_r)
    `CHK("high", 8'had, prod_r.high_byte)
    `CHK("w", 8'he2, wreg_r)
    `CHK("phase", PH_DECODE, phase_r)
  endtask
  // Largest product keeps all sixteen bits; zero product leaves flags alone
  task automatic t_bounds;
    mul_decoder_model_inst.run(8'hff, 8'hff, 8'h0d);
    `CHK("max", 16'hfe01, prod_r)
    status_in = 8'hff;
    mul_decoder_model_inst.run(8'h00, 8'hff, 8'h0d);
    `CHK("zero", 16'h0000, prod_r)
    `CHK("flags", 8'hff, status_r)
  endtask
  // Another opcode is ignored and the pair keeps its value
  task automatic t_refuse;
    mul_decoder_model_inst.run(8'h03, 8'h03, 8'h0e);
    `CHK("nodone", 1'b0, done_r)
    `CHK("kept", 16'h0000, prod_r)
  endtask
  task automatic complete_run;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    t_example();
    t_bounds();
    t_refuse();
    complete_run();
  end
  // Watchdog well beyond the few dozen cycles the tests need
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule
